// *** pkg/gpe_pkg.sv ***
package gpe_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_GPI = 5;
   localparam int NUM_MFUNC = 7;

   localparam logic [7:0] OFS_EVENT_STATUS = 8'hA8;
   localparam logic [7:0] OFS_EVENT_ENABLE = 8'hAA;
   localparam logic [7:0] OFS_PIN_INPUT_LEVELS = 8'hAC;
   localparam logic [7:0] OFS_PIN_OUTPUT_LEVELS = 8'hAE;

   localparam int BIT_VIDEO = 15;
   localparam int BIT_POWER = 11;
   localparam int BIT_VPP12 = 8;

   // writable / settable bits of status and enable, then of the output levels
   localparam logic [15:0] EVENT_MASK = 16'h891F;
   localparam logic [15:0] GPIO_MASK = 16'h001F;

   localparam logic [15:0] RST_EVENT_STATUS = 16'h0000;
   localparam logic [15:0] RST_EVENT_ENABLE = 16'h0000;
   localparam logic [15:0] RST_PIN_OUTPUT = 16'h0000;
   localparam logic [15:0] RST_RDATA = 16'h0000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } gpe_cfg_req_t;

   // pin mux state, owned by the configuration logic outside this block
   typedef struct packed {
      logic [6:0] event_sel;
      logic [4:0] gpi_sel;
      logic [4:0] gpo_sel;
   } gpe_pin_cfg_t;

   // socket state whose software-driven changes raise events
   typedef struct packed {
      logic video_port_enable;
      logic [3:0] power_state;
      logic vpp12_req;
   } gpe_socket_t;

endpackage

// *** rtl/gpe_change_det.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpe_change_det #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] changed
);
   logic [WIDTH-1:0] prev_q;
   logic armed_q;

   // first sample after reset only arms the detector, so no spurious event
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_q <= '0;
         armed_q <= 1'b0;
      end
      else
      begin
         prev_q <= level;
         armed_q <= 1'b1;
      end
   end

   assign changed = armed_q ? (level ^ prev_q) : '0;
endmodule
`default_nettype wire

// *** rtl/gpe_event_io.sv ***
// Overview of operation
// - The event output stays asserted until software clears the matching status or enable bit, or the pin mux changes.
// - The event output is driven only while some multifunction pin 6..0 is set for events.
// - With enable bit 15 set, a change of the video-port enable bit raises an event.
// - With enable bit 11 set, a software change of socket power state raises an event.
// - With enable bit 8 set, a change of the 12 V programming-voltage request raises an event.
// - Enable bits 4..0 raise events on level changes of pins 5,4,2,1,0 only while set as inputs.
// - Enable bits 14..12, 10..9 and 7..5 are read-only zero.
// - Input register bits 4..0 return the present levels of pins 5,4,2,1,0; writes do nothing.
// - Bits 15..5 of the input and output registers are read-only zero.
// - Output register bits 4..0 set pins 5,4,2,1,0 while each is configured as an output.
// - Reading output register bits 4..0 returns the last written value, not the pin.
// - Status bits set on their event whatever the enable, and writing one clears them.
// - Status bit 15 is video, 11 power, 8 voltage request, 4..0 the five input pins.
`timescale 1ns/1ps
`default_nettype none
module gpe_event_io #(
   parameter int NUM_GPI = 5
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire gpe_pkg::gpe_cfg_req_t cfg_req,
   output logic [15:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire gpe_pkg::gpe_pin_cfg_t pin_cfg,
   input wire gpe_pkg::gpe_socket_t socket,
   input wire logic [NUM_GPI-1:0] multipin_in,
   output logic [NUM_GPI-1:0] multipin_out,
   output logic [NUM_GPI-1:0] multipin_oe,
   output logic general_event_out_n,
   output logic general_event_oe
);
   import gpe_pkg::*;

   logic [15:0] status_q;
   wire [15:0] status_d;
   logic [15:0] enable_q;
   logic [15:0] enable_d;
   logic [15:0] out_lvl_q;
   logic [15:0] out_lvl_d;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic event_n_q;
   logic event_oe_q;
   logic [NUM_GPI-1:0] pin_out_q;
   logic [NUM_GPI-1:0] pin_oe_q;

   // byte-lane write mask and decodes
   wire [15:0] lane_mask = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
   wire [15:0] wr_bits = cfg_req.wdata & lane_mask;
   wire hit_status = cfg_req.addr == OFS_EVENT_STATUS;
   wire hit_enable = cfg_req.addr == OFS_EVENT_ENABLE;
   wire hit_input = cfg_req.addr == OFS_PIN_INPUT_LEVELS;
   wire hit_output = cfg_req.addr == OFS_PIN_OUTPUT_LEVELS;
   wire wr_status = cfg_req.wr && hit_status;
   wire wr_enable = cfg_req.wr && hit_enable;
   wire wr_output = cfg_req.wr && hit_output;

   // change detection on socket state and input pin levels
   logic [5:0] sock_chg;
   logic [NUM_GPI-1:0] pin_chg;

   gpe_change_det #(
      .WIDTH(6)
   ) u_sock_det (
      .clock(clock),
      .rst_n(rst_n),
      .level({socket.video_port_enable, socket.power_state, socket.vpp12_req}),
      .changed(sock_chg)
   );

   gpe_change_det #(
      .WIDTH(NUM_GPI)
   ) u_pin_det (
      .clock(clock),
      .rst_n(rst_n),
      .level(multipin_in),
      .changed(pin_chg)
   );

   logic [15:0] event_set;
   always_comb
   begin
      event_set = '0;
      event_set[BIT_VIDEO] = sock_chg[5];
      event_set[BIT_POWER] = |sock_chg[4:1];
      event_set[BIT_VPP12] = sock_chg[0];
      event_set[NUM_GPI-1:0] = pin_chg;
   end

   // set wins over a write-one clear landing in the same cycle
   wire [15:0] status_clr = wr_status ? wr_bits : 16'h0000;

   // one sticky flag per bit; reserved positions are tied low
   for (genvar b = 0; b < DATA_W; b = b + 1)
   begin : g_flag
      if (EVENT_MASK[b])
      begin : g_live
         assign status_d[b] = event_set[b] || (status_q[b] && !status_clr[b]);
      end
      else
      begin : g_rsvd
         assign status_d[b] = 1'b0;
      end
   end

   assign enable_d = wr_enable
      ? (((enable_q & ~lane_mask) | wr_bits) & EVENT_MASK) : enable_q;
   assign out_lvl_d = wr_output
      ? (((out_lvl_q & ~lane_mask) | wr_bits) & GPIO_MASK) : out_lvl_q;

   // input pin events only count while the pin is muxed as an input
   wire [15:0] src_live;
   for (genvar b = 0; b < DATA_W; b = b + 1)
   begin : g_src
      if (b < NUM_GPI)
      begin : g_pin
         assign src_live[b] = status_q[b] && enable_q[b] && pin_cfg.gpi_sel[b];
      end
      else
      begin : g_sock
         assign src_live[b] = status_q[b] && enable_q[b];
      end
   end
   wire pending = |src_live;
   wire any_event_pin = |pin_cfg.event_sel;

   wire [15:0] in_word = {{(16-NUM_GPI){1'b0}}, multipin_in};
   wire [15:0] rd_mux =
      hit_status ? status_q :
      hit_enable ? enable_q :
      hit_input ? in_word :
      hit_output ? out_lvl_q : 16'h0000;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_q <= RST_EVENT_STATUS;
      end
      else
      begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_q <= RST_EVENT_ENABLE;
      end
      else
      begin
         enable_q <= enable_d;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_lvl_q <= RST_PIN_OUTPUT;
      end
      else
      begin
         out_lvl_q <= out_lvl_d;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= RST_RDATA;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rdata_q <= cfg_req.rd ? rd_mux : RST_RDATA;
         rvalid_q <= cfg_req.rd;
      end
   end

   // outputs registered; output stays high (idle) unless a pin carries events
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         event_n_q <= 1'b1;
         event_oe_q <= 1'b0;
      end
      else
      begin
         event_n_q <= ~(pending && any_event_pin);
         event_oe_q <= any_event_pin;
      end
   end

   // one flop pair per output pin; a deselected pin drops its output enable and holds its out bit low, not a stale level
   for (genvar i = 0; i < NUM_GPI; i = i + 1)
   begin : g_pin_out
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            pin_out_q[i] <= 1'b0;
            pin_oe_q[i] <= 1'b0;
         end
         else
         begin
            pin_out_q[i] <= out_lvl_q[i] && pin_cfg.gpo_sel[i];
            pin_oe_q[i] <= pin_cfg.gpo_sel[i];
         end
      end
   end

   assign cfg_rdata = rdata_q;
   assign cfg_rvalid = rvalid_q;
   assign multipin_out = pin_out_q;
   assign multipin_oe = pin_oe_q;
   assign general_event_out_n = event_n_q;
   assign general_event_oe = event_oe_q;
endmodule
`default_nettype wire

// *** sim/gpe_event_io_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpe_event_io_assertions
   import gpe_pkg::*;
#(
   parameter int NUM_GPI = 5
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire gpe_pkg::gpe_cfg_req_t cfg_req,
   input wire logic [15:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire gpe_pkg::gpe_pin_cfg_t pin_cfg,
   input wire logic [NUM_GPI-1:0] multipin_out,
   input wire logic [NUM_GPI-1:0] multipin_oe,
   input wire logic general_event_out_n,
   input wire logic general_event_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_rd_lat:
      assert property (cfg_rvalid == $past(cfg_req.rd)) else $error("rd lat");
   a_io_rsvd:
      assert property (cfg_rvalid && $past(cfg_req.addr[2]) |-> !(|cfg_rdata[15:5]))
      else $error("io rsvd");
   a_ev_rsvd:
      assert property (cfg_rvalid && $past(cfg_req.addr[7:2]) == 6'h2A
         |-> !(|(cfg_rdata & ~EVENT_MASK))) else $error("ev rsvd");
   a_oe_sel:
      assert property (multipin_oe == $past(pin_cfg.gpo_sel)) else $error("oe");
   a_out_oe:
      assert property (!(|(multipin_out & ~multipin_oe))) else $error("out");
   a_ev_oe:
      assert property (general_event_oe == (|$past(pin_cfg.event_sel))) else $error("ev oe");
   a_ev_gate:
      assert property (!general_event_oe |-> general_event_out_n) else $error("ev gate");
   a_ev_hold:
      assert property (!general_event_out_n && !$past(cfg_req.wr) && $stable(pin_cfg)
         |=> !general_event_out_n) else $error("ev hold");
   c_event: cover property ($fell(general_event_out_n));
   c_read: cover property (cfg_rvalid);
   c_drive: cover property (|multipin_out);
endmodule
bind gpe_event_io gpe_event_io_assertions #(.NUM_GPI(NUM_GPI)) u_gpe_event_io_assertions (
   .clock(clock),
   .rst_n(rst_n),
   .cfg_req(cfg_req),
   .cfg_rdata(cfg_rdata),
   .cfg_rvalid(cfg_rvalid),
   .pin_cfg(pin_cfg),
   .multipin_out(multipin_out),
   .multipin_oe(multipin_oe),
   .general_event_out_n(general_event_out_n),
   .general_event_oe(general_event_oe)
);
`default_nettype wire

// *** sim/gpe_pin_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpe_pin_partner (
   input wire logic [4:0] ext,
   input wire logic [4:0] out,
   input wire logic [4:0] oe,
   output logic [4:0] pins
);
   // a driven pin reads back its own level
   assign pins = (oe & out) | (~oe & ext);
endmodule
`default_nettype wire

// *** sim/gpe_event_io_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpe_event_io_test;
   import gpe_pkg::*;
   logic clock = 0;
   logic rst_n = 0;
   logic cfg_rvalid, general_event_out_n, general_event_oe;
   logic [15:0] cfg_rdata;
   logic [4:0] ext = '0, multipin_in, multipin_out, multipin_oe;
   gpe_cfg_req_t cfg_req = '0;
   gpe_pin_cfg_t pin_cfg = '{7'h00, 5'h1F, 5'h00};
   gpe_socket_t socket = '0;
   int n_errors = 0, n_compared = 0;
   always #2.5 clock = ~clock;
   gpe_event_io u_gpe_event_io (
      .clock(clock),
      .rst_n(rst_n),
      .cfg_req(cfg_req),
      .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid),
      .pin_cfg(pin_cfg),
      .socket(socket),
      .multipin_in(multipin_in),
      .multipin_out(multipin_out),
      .multipin_oe(multipin_oe),
      .general_event_out_n(general_event_out_n),
      .general_event_oe(general_event_oe)
   );
   gpe_pin_partner u_gpe_pin_partner (.ext(ext), .out(multipin_out), .oe(multipin_oe),
      .pins(multipin_in));
   task automatic chk(input logic [16:0] s, e);
      n_compared++;
      n_errors += int'(s !== e);
      if (s !== e)
         $display("unexpected %0t %h %h", $time, s, e);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d of %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // write when w, else read and expect d
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      cfg_req <= '{w, !w, a, 2'b11, d};
      @(posedge clock);
      cfg_req <= '0;
      #1;
      if (!w)
         chk({cfg_rvalid, cfg_rdata}, {1'b1, d});
   endtask
   task automatic ev(input int n, input logic e);
      repeat (n) @(posedge clock);
      #1;
      chk(17'(general_event_out_n), 17'(e));
   endtask
   initial
   begin
      #20000;
      n_errors++;
      tally_and_finish;
   end
   initial
   begin
      repeat (10) @(posedge clock);
      rst_n <= 1;
      acc(0, 8'hAA, 16'h0000);
      acc(0, 8'hAE, 16'h0000);
      acc(1, 8'hAA, 16'hFFFF);
      acc(0, 8'hAA, 16'h891F);
      @(posedge clock) cfg_req <= '{1'b1, 1'b0, 8'hAA, 2'b10, 16'h0000};
      @(posedge clock) cfg_req <= '0;
      acc(0, 8'hAA, 16'h001F);
      acc(1, 8'hAA, 16'hFFFF);
      acc(1, 8'hAE, 16'hFFEA);
      acc(0, 8'hAE, 16'h000A);
      @(posedge clock) pin_cfg.gpo_sel <= 5'h1F;
      ev(3, 1'b1);
      chk(17'(multipin_out), 17'h0000A);
      chk(17'(multipin_oe), 17'h0001F);
      chk(17'(general_event_oe), 17'h00000);
      @(posedge clock) pin_cfg.gpo_sel <= 5'h00;
      ev(3, 1'b1);
      chk(17'(multipin_out), 17'h00000);
      chk(17'(multipin_oe), 17'h00000);
      acc(1, 8'hA8, 16'hFFFF);
      acc(0, 8'hA8, 16'h0000);
      @(posedge clock) ext <= 5'h15;
      ev(3, 1'b1);
      acc(1, 8'hAC, 16'hFFFF);
      acc(0, 8'hAC, 16'h0015);
      acc(0, 8'hA8, 16'h0015);
      @(posedge clock) pin_cfg.event_sel <= 7'h40;
      ev(3, 1'b0);
      chk(17'(general_event_oe), 17'h00001);
      acc(1, 8'hA8, 16'h0005);
      ev(2, 1'b0);
      acc(1, 8'hA8, 16'h0010);
      ev(2, 1'b1);
      @(posedge clock) socket <= '{1'b1, 4'h3, 1'b1};
      ev(3, 1'b0);
      acc(0, 8'hA8, 16'h8900);
      acc(1, 8'hAA, 16'h0000);
      ev(2, 1'b1);
      acc(1, 8'hA8, 16'hFFFF);
      acc(1, 8'hAA, 16'h001F);
      @(posedge clock) pin_cfg.gpi_sel <= 5'h00;
      @(posedge clock) ext <= 5'h00;
      ev(3, 1'b1);
      acc(0, 8'hA8, 16'h0015);
      tally_and_finish;
   end
endmodule
`default_nettype wire
